// *** verilog/rxpc_pkg.sv ***
// Purpose: constants shared by the receive payload control block
// Assumes: one T1/J1 link, 24 channels, 8-bit indirect registers
// Notes:   bit 1 of a channel byte (first on the line) is bit 7 here
package rxpc_pkg;
    localparam int unsigned NUM_CHAN = 24;

    // indirect address ranges, one address per channel
    localparam logic [6:0] ADDR_CHAN_FIRST = 7'h01;
    localparam logic [6:0] ADDR_CHAN_LAST  = 7'h18;
    localparam logic [6:0] ADDR_DTRK_FIRST = 7'h21;
    localparam logic [6:0] ADDR_DTRK_LAST  = 7'h38;
    localparam logic [6:0] ADDR_STRK_FIRST = 7'h41;
    localparam logic [6:0] ADDR_STRK_LAST  = 7'h58;

    // access spaces selected with the address
    localparam logic SPACE_EXTRACT = 1'b0;
    localparam logic SPACE_PAYLOAD = 1'b1;

    // extract buffer register fields
    localparam int unsigned EXT_EN_BIT   = 4;
    localparam logic [7:0]  EXT_RESET    = 8'h10;

    // channel control register fields
    localparam int unsigned CTRL_SEL_LSB  = 5;
    localparam int unsigned CTRL_MSB_INV  = 4;
    localparam int unsigned CTRL_ODD_INV  = 3;
    localparam int unsigned CTRL_EVEN_INV = 2;
    localparam int unsigned CTRL_LSB_CLOCK_GAP_FLAG     = 1;
    localparam int unsigned CTRL_GAP      = 0;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [7:0]  DTRK_RESET    = 8'h00;

    // signaling trunk register fields
    localparam int unsigned STRK_TEST_BIT = 6;
    localparam int unsigned STRK_EN_BIT   = 4;
    localparam logic [7:0]  STRK_WMASK    = 8'h5F;
    localparam logic [7:0]  STRK_RESET    = 8'h00;

    // replacement codes
    localparam logic [2:0] REPL_NONE  = 3'h0;
    localparam logic [2:0] REPL_TRUNK = 3'h1;
    localparam logic [2:0] REPL_ALAW  = 3'h2;
    localparam logic [2:0] REPL_MULAW = 3'h3;

    // prbs width modes
    localparam logic [1:0] PRBS_MODE_8BIT = 2'h1;
    localparam logic [1:0] PRBS_MODE_7BIT = 2'h2;

    // inversion and gap masks, bit 1 = msb
    localparam logic [7:0] MASK_MSB  = 8'h80;
    localparam logic [7:0] MASK_ODD  = 8'h2A;
    localparam logic [7:0] MASK_EVEN = 8'h55;
    localparam logic [7:0] MASK_LSB  = 8'h01;
    localparam logic [7:0] MASK_ALL  = 8'hFF;

    // digital milliwatt sequences, one byte per frame
    localparam logic [7:0] ALAW_MW [8] = '{8'h34, 8'h21, 8'h21, 8'h34,
                                           8'hB4, 8'hA1, 8'hA1, 8'hB4};
    localparam logic [7:0] MULAW_MW [8] = '{8'h1E, 8'h0B, 8'h0B, 8'h1E,
                                            8'h9E, 8'h8B, 8'h8B, 8'h9E};

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_ACCESS = 2'b10
    } rxpc_acc_state_e;
endpackage : rxpc_pkg

// *** verilog/rxpc_slot_proc.sv ***
// Purpose: per-timeslot payload and signaling conditioning
// Assumes: one timeslot byte per ts_valid, settings of that channel given
// Notes:   outputs other than prbs_gen_take registered one cycle after ts_valid
`timescale 1ns/1ps
`default_nettype none
module rxpc_slot_proc
    import rxpc_pkg::*;
(
    input  wire logic       sys_clk,        // device clock
    input  wire logic       rst,            // sync reset, active high
    input  wire logic       ts_valid,       // timeslot byte strobe
    input  wire logic [4:0] chan,           // channel index 0..23
    input  wire logic [7:0] data_in,        // received channel byte
    input  wire logic [7:0] ctrl,           // channel control register
    input  wire logic [7:0] dtrk,           // data trunk code
    input  wire logic [7:0] strk,           // signaling trunk register
    input  wire logic [3:0] sig_in,         // extracted signaling
    input  wire logic [2:0] mw_phase,       // milliwatt frame phase
    input  wire logic [2:0] global_replace_sel,         // global replace
    input  wire logic       global_sig_trunk_enable,    // all channels
    input  wire logic       gapped_clock_global_enable, // gap enable
    input  wire logic       rx_clock_master,            // clock master
    input  wire logic [1:0] prbs_width_sel,             // prbs mode
    input  wire logic       prbs_direction_sel,         // 1 = generate
    input  wire logic [7:0] prbs_gen_data,  // next generator byte
    output logic            prbs_gen_take,  // generator byte consumed
    output logic            out_valid,      // output strobe
    output logic [4:0]      out_chan,       // output channel
    output logic [7:0]      out_data,       // conditioned byte
    output logic [3:0]      out_sig,        // conditioned signaling
    output logic [7:0]      out_gap_mask,   // 1 = clock pulse removed
    output logic            prbs_det_valid, // byte to detector
    output logic [7:0]      prbs_det_data,  // detector byte
    output logic            prbs_det_7bit   // only 7 msbs valid
);
    wire       [2:0] sel_eff    = (global_replace_sel != REPL_NONE) ?
                                  global_replace_sel :
                                  ctrl[CTRL_SEL_LSB +: 3];
    wire             test_on    = strk[STRK_TEST_BIT];
    wire             mode_8     = (prbs_width_sel == PRBS_MODE_8BIT);
    wire             mode_7     = (prbs_width_sel == PRBS_MODE_7BIT);
    wire             prbs_mode  = mode_8 | mode_7;
    wire             gap_active = rx_clock_master &
                                  gapped_clock_global_enable;
    wire             sig_trunk  = global_sig_trunk_enable |
                                  strk[STRK_EN_BIT];
    wire       [7:0] inv_mask   =
        (ctrl[CTRL_MSB_INV]  ? MASK_MSB  : 8'h00) |
        (ctrl[CTRL_ODD_INV]  ? MASK_ODD  : 8'h00) |
        (ctrl[CTRL_EVEN_INV] ? MASK_EVEN : 8'h00);
    wire       [7:0] gap_mask   = !gap_active      ? 8'h00 :
                                  ctrl[CTRL_GAP]  ? MASK_ALL :
                                  ctrl[CTRL_LSB_CLOCK_GAP_FLAG] ? MASK_LSB :
                                  8'h00;
    logic      [7:0] repl_data;
    logic      [7:0] slot_data;

    always_comb begin
        unique case (sel_eff)
            REPL_TRUNK: repl_data = dtrk;
            REPL_ALAW:  repl_data = ALAW_MW[mw_phase];
            REPL_MULAW: repl_data = MULAW_MW[mw_phase];
            default:    repl_data = data_in;
        endcase
    end

    // one generator byte per selected slot keeps the sequence continuous
    assign prbs_gen_take = ts_valid & test_on & prbs_mode &
                           prbs_direction_sel;

    always_comb begin
        slot_data = repl_data ^ inv_mask;
        if (prbs_gen_take) begin
            // 7-bit mode keeps the lsb of the replaced and inverted byte
            slot_data = mode_8 ? prbs_gen_data :
                        {prbs_gen_data[7:1], slot_data[0]};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_valid      <= 1'b0;
            out_chan       <= 5'h00;
            out_data       <= 8'h00;
            out_sig        <= 4'h0;
            out_gap_mask   <= 8'h00;
            prbs_det_valid <= 1'b0;
            prbs_det_data  <= 8'h00;
            prbs_det_7bit  <= 1'b0;
        end else begin
            out_valid      <= ts_valid;
            prbs_det_valid <= ts_valid & test_on & prbs_mode &
                              !prbs_direction_sel;
            if (ts_valid) begin
                out_chan      <= chan;
                out_data      <= slot_data;
                out_sig       <= sig_trunk ? strk[3:0] : sig_in;
                out_gap_mask  <= gap_mask;
                prbs_det_data <= data_in;
                prbs_det_7bit <= mode_7;
            end
        end
    end
endmodule : rxpc_slot_proc
`default_nettype wire

// *** verilog/rxpc_top.sv ***
// Purpose: receive signaling extraction and payload control, 24 channels
// Assumes: framer gives one byte strobe per timeslot and frame start
// Notes:   indirect registers reached through access data/control ports
//
// Summary of operation
// - 24 extract registers at addresses 01h-18h
// - capture signaling when enabled and frame synced
// - extracted ABCD fields read-only, valid when enabled
// - SF format repeats A,B into C,D
// - payload addresses: control, data trunk, signaling trunk
// - channel replacement only when global selection zero
// - decode no change, trunk, A-law, mu-law milliwatt
// - msb, odd, even inversion flags combine
// - gapping only as clock master with enable
// - 56K gaps bit 8; full gap whole channel
// - data trunk byte replaces channel data
// - test flag routes to detector or generator
// - 8-bit or 7-msb prbs per width mode
// - selected channels form one continuous prbs stream
// - signaling trunk enable substitutes ABCD trunk code
// - global or channel trunk enable selects channel
// - signaling change sets flag; write one clears
`timescale 1ns/1ps
`default_nettype none
module rxpc_top
    import rxpc_pkg::*;
(
    input  wire logic        sys_clk,            // 250 MHz clock
    input  wire logic        rst,                // sync reset, active high
    // received timeslot stream
    input  wire logic        rx_frame_start,     // ts_valid is channel 1
    input  wire logic        rx_ts_valid,        // one strobe per timeslot
    input  wire logic [7:0]  rx_ts_data,         // received channel byte
    input  wire logic        rx_sig_valid,       // slot carries signaling
    input  wire logic [3:0]  rx_sig_bits,        // received A,B,C,D
    // framer and global settings
    input  wire logic        frame_synced,       // SF/ESF/SLC-96 in sync
    input  wire logic        sf_format,          // SF format selected
    input  wire logic        rx_clock_master,    // receive clock master
    input  wire logic        gapped_clock_global_enable, // gap enable
    input  wire logic [2:0]  global_replace_sel, // global replacement
    input  wire logic        global_sig_trunk_enable, // trunk all
    input  wire logic [1:0]  prbs_width_sel,     // prbs width mode
    input  wire logic        prbs_direction_sel, // 0 detect, 1 generate
    // indirect access
    input  wire logic        acc_data_we,        // write access data reg
    input  wire logic [7:0]  acc_data_wdata,     // access data value
    input  wire logic        acc_ctrl_we,        // write access control
    input  wire logic        acc_ctrl_space,     // 0 extract, 1 payload
    input  wire logic [6:0]  acc_ctrl_addr,      // indirect address
    input  wire logic        read_not_write_flag, // 1 read, 0 write
    output logic [7:0]       acc_data_rdata,     // access data register
    output logic             acc_busy,           // access in progress
    // change of signaling
    input  wire logic        cos_clear_we,       // write to change flags
    input  wire logic [23:0] cos_clear_mask,     // 1 clears that flag
    output logic [23:0]      sig_change_flag,    // per-channel change
    // conditioned stream
    output logic             out_valid,          // output byte strobe
    output logic [4:0]       out_chan,           // output channel 0..23
    output logic [7:0]       out_data,           // conditioned byte
    output logic [3:0]       out_sig,            // conditioned signaling
    output logic [7:0]       out_gap_mask,       // 1 = clock suppressed
    // prbs generator/detector
    output logic             prbs_det_valid,     // byte to detector
    output logic [7:0]       prbs_det_data,      // detector byte
    output logic             prbs_det_7bit,      // only 7 msbs count
    output logic             prbs_gen_take,      // generator byte used
    input  wire logic [7:0]  prbs_gen_data       // generator byte
);
    localparam logic [4:0] LAST_CHAN = 5'(NUM_CHAN - 1);

    // ---------------- channel counter ----------------
    logic [4:0] chan_next_q;
    logic [4:0] chan_next_d;
    logic [2:0] mw_phase_q;
    logic [2:0] mw_phase_d;
    wire  [4:0] chan_cur = rx_frame_start ? 5'h00 : chan_next_q;

    // holds at the last channel if frame start is late, so no index
    // beyond the arrays is ever formed
    assign chan_next_d = !rx_ts_valid ? chan_next_q :
                         (chan_cur == LAST_CHAN) ? LAST_CHAN :
                         5'(chan_cur + 5'h01);
    assign mw_phase_d  = (rx_ts_valid & rx_frame_start) ?
                         3'(mw_phase_q + 3'h1) : mw_phase_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            chan_next_q <= 5'h00;
            mw_phase_q  <= 3'h0;
        end else begin
            chan_next_q <= chan_next_d;
            mw_phase_q  <= mw_phase_d;
        end
    end

    // ---------------- indirect access sequencer ----------------
    rxpc_acc_state_e state_q;
    rxpc_acc_state_e state_d;
    logic            space_q;
    logic [6:0]      addr_q;
    logic            rnw_q;
    logic [7:0]      acc_data_q;
    logic [7:0]      acc_data_d;
    logic [7:0]      rd_value;

    // a new address write while busy is ignored
    wire ctrl_take = acc_ctrl_we & (state_q == ST_IDLE);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:   if (ctrl_take) state_d = ST_ACCESS;
            ST_ACCESS: state_d = ST_IDLE;
            default:   state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            space_q <= SPACE_EXTRACT;
            addr_q  <= 7'h00;
            rnw_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            if (ctrl_take) begin
                space_q <= acc_ctrl_space;
                addr_q  <= acc_ctrl_addr;
                rnw_q   <= read_not_write_flag;
            end
        end
    end

    assign acc_busy = (state_q == ST_ACCESS);

    // address decode, one address per channel
    wire       in_chan  = (addr_q >= ADDR_CHAN_FIRST) &&
                          (addr_q <= ADDR_CHAN_LAST);
    wire       in_dtrk  = (addr_q >= ADDR_DTRK_FIRST) &&
                          (addr_q <= ADDR_DTRK_LAST);
    wire       in_strk  = (addr_q >= ADDR_STRK_FIRST) &&
                          (addr_q <= ADDR_STRK_LAST);
    wire [4:0] idx_chan = 5'(addr_q - ADDR_CHAN_FIRST);
    wire [4:0] idx_dtrk = 5'(addr_q - ADDR_DTRK_FIRST);
    wire [4:0] idx_strk = 5'(addr_q - ADDR_STRK_FIRST);
    wire       do_wr    = acc_busy & !rnw_q;
    wire       do_rd    = acc_busy & rnw_q;
    wire       wr_ext   = do_wr & (space_q == SPACE_EXTRACT) & in_chan;
    wire       wr_ctrl  = do_wr & (space_q == SPACE_PAYLOAD) & in_chan;
    wire       wr_dtrk  = do_wr & (space_q == SPACE_PAYLOAD) & in_dtrk;
    wire       wr_strk  = do_wr & (space_q == SPACE_PAYLOAD) & in_strk;

    // read result overrides a same-cycle data write: the fetched byte
    // is what software asked for
    assign acc_data_d = do_rd       ? rd_value :
                        acc_data_we ? acc_data_wdata : acc_data_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            acc_data_q <= 8'h00;
        end else begin
            acc_data_q <= acc_data_d;
        end
    end

    assign acc_data_rdata = acc_data_q;

    // ---------------- register storage ----------------
    logic [NUM_CHAN-1:0] ext_en_q;
    logic [7:0]          ctrl_q [NUM_CHAN];
    logic [7:0]          dtrk_q [NUM_CHAN];
    logic [7:0]          strk_q [NUM_CHAN];
    logic [3:0]          sig_abcd [NUM_CHAN];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ext_en_q <= {NUM_CHAN{EXT_RESET[EXT_EN_BIT]}};
        end else if (wr_ext) begin
            // only the enable is writable, A-D belong to the hardware
            ext_en_q[idx_chan] <= acc_data_q[EXT_EN_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                ctrl_q[i] <= CTRL_RESET;
                dtrk_q[i] <= DTRK_RESET;
                strk_q[i] <= STRK_RESET;
            end
        end else begin
            if (wr_ctrl) begin
                ctrl_q[idx_chan] <= acc_data_q;
            end
            if (wr_dtrk) begin
                dtrk_q[idx_dtrk] <= acc_data_q;
            end
            if (wr_strk) begin
                strk_q[idx_strk] <= acc_data_q & STRK_WMASK;
            end
        end
    end

    // unmapped addresses read as zero
    always_comb begin
        rd_value = 8'h00;
        if (space_q == SPACE_EXTRACT) begin
            if (in_chan) begin
                rd_value = {3'h0, ext_en_q[idx_chan],
                            sig_abcd[idx_chan]};
            end
        end else if (in_chan) begin
            rd_value = ctrl_q[idx_chan];
        end else if (in_dtrk) begin
            rd_value = dtrk_q[idx_dtrk];
        end else if (in_strk) begin
            rd_value = strk_q[idx_strk];
        end
    end

    // ---------------- signaling extraction ----------------
    // sf carries only A and B; they are repeated into C and D
    wire [3:0] sig_new = sf_format ?
                         {rx_sig_bits[3:2], rx_sig_bits[3:2]} :
                         rx_sig_bits;
    wire       sig_slot = rx_ts_valid & rx_sig_valid & frame_synced;

    for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
        logic [3:0] abcd_q;
        logic       cos_q;
        logic       cos_d;
        // enable low freezes the fields; DM mode relies on software
        // having cleared every enable
        wire        hit = sig_slot & ext_en_q[ch] &
                          (chan_cur == 5'(ch));
        wire        chg = hit & (sig_new != abcd_q);
        wire        clr = cos_clear_we & cos_clear_mask[ch];

        // a change in the clearing cycle keeps the flag set
        assign cos_d = chg | (cos_q & !clr);

        always_ff @(posedge sys_clk) begin
            if (rst) begin
                abcd_q <= 4'h0;
                cos_q  <= 1'b0;
            end else begin
                cos_q <= cos_d;
                if (hit) begin
                    abcd_q <= sig_new;
                end
            end
        end

        assign sig_abcd[ch]        = abcd_q;
        assign sig_change_flag[ch] = cos_q;
    end

    // ---------------- timeslot conditioning ----------------
    rxpc_slot_proc u_slot (
        .sys_clk                    (sys_clk),
        .rst                        (rst),
        .ts_valid                   (rx_ts_valid),
        .chan                       (chan_cur),
        .data_in                    (rx_ts_data),
        .ctrl                       (ctrl_q[chan_cur]),
        .dtrk                       (dtrk_q[chan_cur]),
        .strk                       (strk_q[chan_cur]),
        .sig_in                     (sig_abcd[chan_cur]),
        .mw_phase                   (mw_phase_q),
        .global_replace_sel         (global_replace_sel),
        .global_sig_trunk_enable    (global_sig_trunk_enable),
        .gapped_clock_global_enable (gapped_clock_global_enable),
        .rx_clock_master            (rx_clock_master),
        .prbs_width_sel             (prbs_width_sel),
        .prbs_direction_sel         (prbs_direction_sel),
        .prbs_gen_data              (prbs_gen_data),
        .prbs_gen_take              (prbs_gen_take),
        .out_valid                  (out_valid),
        .out_chan                   (out_chan),
        .out_data                   (out_data),
        .out_sig                    (out_sig),
        .out_gap_mask               (out_gap_mask),
        .prbs_det_valid             (prbs_det_valid),
        .prbs_det_data              (prbs_det_data),
        .prbs_det_7bit              (prbs_det_7bit)
    );
endmodule : rxpc_top
`default_nettype wire

// *** verif/rxpc_gen_model.sv ***
// Purpose: generator byte source. Assumes: take pulses. Notes: lfsr model
`timescale 1ns/1ps
`default_nettype none
module rxpc_gen_model (
    input  wire logic       sys_clk, rst, take, // clock, reset, byte used
    output logic      [7:0] data                // next pattern byte
);
    logic [7:0] lfsr_q;
    assign data = lfsr_q;
    // steps only on take, so test slots share one unbroken sequence
    always_ff @(posedge sys_clk)
        lfsr_q <= rst ? 8'h5A : take ? {lfsr_q[6:0], ^(lfsr_q & 8'hB8)}
                                     : lfsr_q;
endmodule : rxpc_gen_model
`default_nettype wire

// *** verif/rxpc_asserts.sv ***
// Purpose: port checks. Assumes: one clock. Notes: bound at foot
`timescale 1ns/1ps
`default_nettype none
module rxpc_asserts import rxpc_pkg::*; (
    input wire logic sys_clk, rst, rx_ts_valid, rx_frame_start, // stream
    input wire logic rx_clock_master, gapped_clock_global_enable, // gap
    input wire logic prbs_direction_sel, acc_ctrl_we, cos_clear_we, // req
    input wire logic acc_busy, out_valid, prbs_det_valid, prbs_det_7bit, // out
    input wire logic [1:0] prbs_width_sel, // prbs mode
    input wire logic [7:0] rx_ts_data, out_gap_mask, prbs_det_data, // bytes
    input wire logic [4:0] out_chan, // slot channel
    input wire logic [23:0] sig_change_flag // change flags
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_busy; acc_busy ##1 !acc_busy; endsequence
    a_busy_pulse: assert property (acc_ctrl_we && !acc_busy |=> s_busy)
        else $error("busy pulse wrong");
    a_slot_answer: assert property (rx_ts_valid |=> out_valid)
        else $error("slot not answered");
    a_chan_align: assert property (rx_ts_valid && rx_frame_start
        |=> out_chan == 5'h00) else $error("channel not aligned");
    a_gap_gated: assert property (rx_ts_valid && !(rx_clock_master
        && gapped_clock_global_enable) |=> out_gap_mask == 8'h00)
        else $error("gap while disabled");
    a_gap_shape: assert property (out_valid |-> out_gap_mask inside
        {8'h00, 8'h01, 8'hFF}) else $error("bad gap mask");
    a_det_raw: assert property (prbs_det_valid |-> $past(rx_ts_valid)
        && !$past(prbs_direction_sel) && prbs_det_data == $past(rx_ts_data))
        else $error("detector byte wrong");
    a_det_width: assert property (prbs_det_valid |-> prbs_det_7bit ==
        ($past(prbs_width_sel) == PRBS_MODE_7BIT)) else $error("width");
    a_flag_sticky: assert property (!cos_clear_we |=>
        (sig_change_flag & $past(sig_change_flag)) == $past(sig_change_flag))
        else $error("flag lost");
endmodule : rxpc_asserts
bind rxpc_top rxpc_asserts u_asserts (.*);
`default_nettype wire

// *** verif/rx_channel_payload_control_test.sv ***
// Purpose: random and corner checks. Assumes: inputs at negedge. Notes: -
`timescale 1ns/1ps
`default_nettype none
module rx_channel_payload_control_test import rxpc_pkg::*;;
    logic sys_clk = 0, rst = 1, rx_frame_start = 0, rx_ts_valid = 0, acc_busy;
    logic rx_sig_valid = 0, frame_synced = 0, sf_format = 0, out_valid;
    logic rx_clock_master = 0, gapped_clock_global_enable = 0, prbs_det_7bit;
    logic global_sig_trunk_enable = 0, prbs_direction_sel = 0, prbs_gen_take;
    logic acc_data_we = 0, acc_ctrl_we = 0, acc_ctrl_space = 0, prbs_det_valid;
    logic read_not_write_flag = 0, cos_clear_we = 0;
    logic [7:0] rx_ts_data = 0, acc_data_wdata = 0, prbs_gen_data, out_data;
    logic [7:0] acc_data_rdata, out_gap_mask, prbs_det_data, stk[24];
    logic [7:0] ctl[24], dtk[24];
    logic [3:0] rx_sig_bits = 0, out_sig;
    logic [2:0] global_replace_sel = 0;
    logic [1:0] prbs_width_sel = 0;
    logic [6:0] acc_ctrl_addr = 0;
    logic [4:0] out_chan;
    logic [23:0] cos_clear_mask = 0, sig_change_flag;
    logic [31:0] seed = 32'h0000_8D65;
    int failures = 0, cmp_count = 0;
    always #2 sys_clk = ~sys_clk;
    rxpc_top u_dut (.*);
    rxpc_gen_model u_gen (.sys_clk, .rst, .take(prbs_gen_take),
                          .data(prbs_gen_data));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    // milliwatt phase is not tracked, so any table byte is accepted
    function automatic bit ok_byte(logic [7:0] o, d, c, t);
        logic [2:0] s = global_replace_sel ? global_replace_sel : c[7:5];
        logic [7:0] x = o ^ ({8{c[4]}} & MASK_MSB) ^ ({8{c[3]}} & MASK_ODD)
                          ^ ({8{c[2]}} & MASK_EVEN);
        return s == REPL_ALAW ? x inside {ALAW_MW} : s == REPL_MULAW ?
               x inside {MULAW_MW} : x === (s == REPL_TRUNK ? t : d);
    endfunction : ok_byte
    task automatic chk(bit ok, string what);
        cmp_count++;
        if (!ok) begin
            failures++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask : chk
    task automatic acc(bit sp, logic [6:0] a, bit rd, logic [7:0] d);
        @(negedge sys_clk) {acc_data_we, acc_data_wdata} = {!rd, d};
        @(negedge sys_clk) {acc_data_we, acc_ctrl_we} = 2'b01;
        {acc_ctrl_space, acc_ctrl_addr, read_not_write_flag} = {sp, a, rd};
        @(negedge sys_clk) acc_ctrl_we = 0;
        @(negedge sys_clk) if (rd) chk(acc_data_rdata === d, "reg");
    endtask : acc
    task automatic slot(int n);
        logic [7:0] d = rnd(), c = ctl[n], g, gp;
        bit tst = stk[n][6] && prbs_width_sel inside {2'h1, 2'h2};
        bit gen = tst && prbs_direction_sel;
        gp = !(rx_clock_master && gapped_clock_global_enable) ? 8'h00
             : c[0] ? 8'hFF : {7'h00, c[1]};
        @(negedge sys_clk) {rx_ts_valid, rx_frame_start, rx_ts_data} = {1'b1, n == 0, d};
        #1 g = prbs_gen_data;
        chk(prbs_gen_take === gen, "take");
        @(negedge sys_clk) rx_ts_valid = 0;
        chk(out_valid === 1'b1 && out_chan === 5'(n), "slot");
        chk(gen ? out_data === g : ok_byte(out_data, d, c, dtk[n]), "data");
        chk(out_gap_mask === gp, "gap");
        chk(out_sig === (global_sig_trunk_enable || stk[n][4] ? stk[n][3:0] : 4'h0), "sig");
        chk(prbs_det_valid === (tst && !prbs_direction_sel) && (!tst || prbs_det_data === d), "det");
    endtask : slot
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        #20_000;
        failures++;
        wrap_up();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk) rst = 0;
        acc(0, 7'h01, 1, EXT_RESET);
        acc(1, 7'h19, 1, 8'h00);
        for (int n = 0; n < 24; n++) begin
            ctl[n] = n == 0 ? 8'h7D : n == 1 ? 8'h22 : rnd();
            dtk[n] = rnd();
            stk[n] = rnd() & STRK_WMASK;
            acc(1, ADDR_CHAN_FIRST + 7'(n), 0, ctl[n]);
            acc(1, ADDR_DTRK_FIRST + 7'(n), 0, dtk[n]);
            acc(1, ADDR_STRK_FIRST + 7'(n), 0, stk[n]);
        end
        acc(1, ADDR_STRK_LAST, 1, stk[23]);
        for (int f = 0; f < 7; f++) begin
            global_replace_sel = f == 1 ? REPL_TRUNK : 3'h0;
            {global_sig_trunk_enable, rx_clock_master} = {f > 2, f != 2};
            gapped_clock_global_enable = f != 3;
            prbs_width_sel = f == 4 ? PRBS_MODE_8BIT : {f == 5, 1'b0};
            prbs_direction_sel = f == 4;
            if (f == 6) begin
                acc(0, 7'h02, 0, 8'h00);
                acc(0, 7'h01, 0, 8'hFF);
                {frame_synced, sf_format, rx_sig_valid, rx_sig_bits} = 7'h7B;
            end
            for (int n = 0; n < 24; n++) slot(n);
        end
        rx_sig_valid = 0;
        acc(0, 7'h01, 1, 8'h1A);
        acc(0, 7'h02, 1, 8'h00);
        chk(sig_change_flag === 24'hFF_FFFD, "flags");
        @(negedge sys_clk) {cos_clear_we, cos_clear_mask} = 25'h100_0001;
        @(negedge sys_clk) cos_clear_we = 0;
        @(negedge sys_clk) chk(sig_change_flag === 24'hFF_FFFC, "clr");
        wrap_up();
    end
endmodule : rx_channel_payload_control_test
`default_nettype wire
